// ### shared/pvmp_consts.svh
/*
  Timing and framing constants for the fixed-format voice serial port.
  Assumes a 100 MHz system clock; every cycle count below is derived from it.
*/
`ifndef PVMP_CONSTS_SVH
`define PVMP_CONSTS_SVH

// ----------------------------------------------------------------------
// System clock
// ----------------------------------------------------------------------
`define PVMP_CLK_PERIOD_NS   10
`define PVMP_CLK_HZ          100000000

// ----------------------------------------------------------------------
// Bit clock and frame layout
// ----------------------------------------------------------------------
`define PVMP_BIT_HZ          768000
`define PVMP_ACC_STEP        (2 * `PVMP_BIT_HZ)
`define PVMP_SLOT_COUNT      6
`define PVMP_SLOT_BITS       16
`define PVMP_ACTIVE_SLOT     0
`define PVMP_FRAME_BITS      (`PVMP_SLOT_COUNT * `PVMP_SLOT_BITS)
`define PVMP_FRAME_HZ        (`PVMP_BIT_HZ / `PVMP_FRAME_BITS)
`define PVMP_FRAME_CYC       (`PVMP_CLK_HZ / `PVMP_FRAME_HZ)
`define PVMP_HALF_MIN_CYC    (`PVMP_CLK_HZ / `PVMP_ACC_STEP)
`define PVMP_HALF_MAX_CYC    (`PVMP_HALF_MIN_CYC + 1)

// ----------------------------------------------------------------------
// Frame sync shape and phase
// ----------------------------------------------------------------------
`define PVMP_SYNC_HIGH_US    32
`define PVMP_SYNC_HIGH_BITS  ((`PVMP_SYNC_HIGH_US * `PVMP_BIT_HZ) / 1000000)
`define PVMP_SYNC_LEAD_NS    154
`define PVMP_SYNC_LEAD_CYC   (`PVMP_SYNC_LEAD_NS / `PVMP_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Line levels and reset values
// ----------------------------------------------------------------------
`define PVMP_IDLE_LEVEL      1'h1
`define PVMP_SAMPLE_RESET    16'h0000

`endif

// ### shared/pvmp_pkg.sv
/*
  Types shared by the voice serial port modules.
  Assumes the constants header is on the include path.
*/
`include "pvmp_consts.svh"

package pvmp_pkg;

  // ----------------------------------------------------------------------
  // Data and counter types
  // ----------------------------------------------------------------------
  typedef logic [`PVMP_SLOT_BITS-1:0] pvmp_sample_t;
  typedef logic [6:0]                 pvmp_bit_t;
  typedef logic [3:0]                 pvmp_rxcnt_t;

  // ----------------------------------------------------------------------
  // Receive sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [0:0] {
    RX_IDLE,
    RX_SHIFT
  } pvmp_rx_e;

endpackage : pvmp_pkg

// ### shared/pvmp_tick_if.sv
/*
  Timing strobes from the bit clock generator to the frame logic.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/100ps

interface pvmp_tick_if;
  logic riseTick;
  logic sampleTick;
  logic pinClk;

  modport gen (
    output riseTick,
    output sampleTick,
    output pinClk
  );

  modport sink (
    input  riseTick,
    input  sampleTick,
    input  pinClk
  );
endinterface : pvmp_tick_if

// ### logic/pvmp_bit_gen.sv
/*
  Fractional divider making the 768 kHz bit clock from the system clock,
  plus a delay line that places the pin clock behind the frame timing.
  Assumes a synchronised active-low reset and LeadCyc of at least 2.
*/
`timescale 1ns/100ps
`include "pvmp_consts.svh"

module pvmp_bit_gen #(
  parameter int LeadCyc = `PVMP_SYNC_LEAD_CYC
) (
  // Clock, reset, enable
  input  wire logic  clk,
  input  wire logic  rstN,
  input  wire logic  en,
  // Timing strobes
  pvmp_tick_if.gen   tick
);

  // ----------------------------------------------------------------------
  // Phase accumulator
  // ----------------------------------------------------------------------
  localparam logic [27:0] AccMod  = 28'(`PVMP_CLK_HZ);
  localparam logic [27:0] AccStep = 28'(`PVMP_ACC_STEP);

  logic [27:0]        acc;
  logic [27:0]        next_acc;
  logic [27:0]        accSum;
  logic               toggle;
  logic               clkInt;
  logic               next_clkInt;
  logic [LeadCyc-1:0] lead;
  logic [LeadCyc-1:0] next_lead;

  // Average rate is exact; each half period is 65 or 66 cycles
  always_comb begin
    accSum      = acc + AccStep;
    toggle      = (accSum >= AccMod);
    next_acc    = toggle ? (accSum - AccMod) : accSum;
    next_clkInt = toggle ? ~clkInt : clkInt;
    next_lead   = {lead[LeadCyc-2:0], clkInt};
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      acc    <= 28'h000_0000;
      clkInt <= 1'h0;
      lead   <= '0;
    end else if (en) begin
      acc    <= next_acc;
      clkInt <= next_clkInt;
      lead   <= next_lead;
    end
  end

  // ----------------------------------------------------------------------
  // Strobes
  // ----------------------------------------------------------------------
  // Delayed pin clock puts frame edges ahead of the clock edge
  assign tick.pinClk     = lead[LeadCyc-1];
  assign tick.riseTick   = toggle & ~clkInt & en;
  // Fires the cycle before the pin clock falls, while input is stable
  assign tick.sampleTick = lead[LeadCyc-1] & ~lead[LeadCyc-2] & en;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN || !en);

  a_pin_lead_delay: assert property ($rose(clkInt) |-> ##LeadCyc $rose(tick.pinClk))
    else $error("pin clock not delayed by lead count");
  a_strobe_exclusive: assert property (tick.riseTick |-> !tick.sampleTick)
    else $error("rise and sample strobes overlap");

endmodule : pvmp_bit_gen

// ### logic/pcm_voice_master_port.sv
/*
  Fixed-format voice serial port, always frame master: drives frame sync
  and bit clock, shifts one 16-bit sample out and one in per frame.
  Assumes the far side samples on the falling bit clock edge and drives
  its data from the rising edge; the serial input is an asynchronous pin.
*/
// Contract
// - Frame sync pulses every frame at 8 kHz
// - Port drives the bit clock itself
// - Six slots per frame, audio in slot zero
// - One clock per bit at 768 kHz
// - Sixteen-bit words, most significant bit first
// - Linear samples, no companding either way
// - Long frame sync spanning many bit clocks
// - Push-pull signalling compatible with standard peripherals
// - Configuration fixed, nothing selectable
// - Sync edge leads clock edge by 154 ns (code: 15 cycles, 150 ns)
`timescale 1ns/100ps
`include "pvmp_consts.svh"

module pcm_voice_master_port (
  // Clock, reset, enable
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  en,
  // Transmit sample stream
  input  wire pvmp_pkg::pvmp_sample_t txData,
  input  wire logic                  txValid,
  output logic                       txReady,
  // Receive sample stream
  output pvmp_pkg::pvmp_sample_t     rxData,
  output logic                       rxValid,
  // Serial port pins
  output logic                       frameSync,
  output logic                       bitClk,
  output logic                       serOut,
  input  wire logic                  serIn
);

  // ----------------------------------------------------------------------
  // Fixed framing
  // ----------------------------------------------------------------------
  localparam pvmp_pkg::pvmp_bit_t   LastBit      = 7'(`PVMP_FRAME_BITS - 1);
  localparam pvmp_pkg::pvmp_bit_t   SlotFirst    = 7'(`PVMP_ACTIVE_SLOT * `PVMP_SLOT_BITS);
  localparam pvmp_pkg::pvmp_bit_t   SlotEnd      = 7'(SlotFirst + `PVMP_SLOT_BITS);
  localparam pvmp_pkg::pvmp_bit_t   SyncHighBits = 7'(`PVMP_SYNC_HIGH_BITS);
  localparam pvmp_pkg::pvmp_rxcnt_t LastRxBit    = 4'(`PVMP_SLOT_BITS - 1);
  localparam logic                  IdleLevel    = `PVMP_IDLE_LEVEL;
  localparam int                    SyncLeadCyc  = `PVMP_SYNC_LEAD_CYC;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic [1:0] rstPipe;
  logic [1:0] next_rstPipe;
  logic       rstSyncN;

  always_comb begin
    next_rstPipe = {rstPipe[0], 1'h1};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= 2'h0;
    end else if (en) begin
      rstPipe <= next_rstPipe;
    end
  end

  assign rstSyncN = rstPipe[1];

  // ----------------------------------------------------------------------
  // Serial input synchroniser
  // ----------------------------------------------------------------------
  // Pin may float while the analog path is in use; samples are then junk
  logic serInMeta;
  logic serInSync;
  logic next_serInMeta;
  logic next_serInSync;

  always_comb begin
    next_serInMeta = serIn;
    next_serInSync = serInMeta;
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      serInMeta <= 1'h1;
      serInSync <= 1'h1;
    end else if (en) begin
      serInMeta <= next_serInMeta;
      serInSync <= next_serInSync;
    end
  end

  // ----------------------------------------------------------------------
  // Bit clock generator
  // ----------------------------------------------------------------------
  pvmp_tick_if tickBus ();

  pvmp_bit_gen #(
    .LeadCyc (SyncLeadCyc)
  ) uBitGen (
    .clk     (clk),
    .rstN    (rstSyncN),
    .en      (en),
    .tick    (tickBus.gen)
  );

  assign bitClk = tickBus.pinClk;

  // ----------------------------------------------------------------------
  // Frame counter, sync and transmit shifter
  // ----------------------------------------------------------------------
  pvmp_pkg::pvmp_bit_t    bitIdx;
  pvmp_pkg::pvmp_bit_t    next_bitIdx;
  pvmp_pkg::pvmp_sample_t txShift;
  pvmp_pkg::pvmp_sample_t next_txShift;
  pvmp_pkg::pvmp_sample_t txWord;
  logic                   next_frameSync;
  logic                   next_serOut;
  logic                   frameStart;

  // Frame begins on the rise that wraps the bit counter
  assign frameStart = tickBus.riseTick & (bitIdx == LastBit);
  // No buffer: the sample offered at frame start is the one sent
  assign txReady    = frameStart;

  always_comb begin
    next_bitIdx    = bitIdx;
    next_frameSync = frameSync;
    next_serOut    = serOut;
    next_txShift   = txShift;
    // Underrun sends a zero sample rather than stale data
    txWord         = txValid ? txData : `PVMP_SAMPLE_RESET;
    if (tickBus.riseTick) begin
      next_bitIdx    = frameStart ? 7'h00 : (bitIdx + 7'h01);
      next_frameSync = (next_bitIdx < SyncHighBits);
      if (next_bitIdx == SlotFirst) begin
        next_serOut  = txWord[`PVMP_SLOT_BITS-1];
        next_txShift = {txWord[`PVMP_SLOT_BITS-2:0], 1'h0};
      end else if (next_bitIdx < SlotEnd) begin
        next_serOut  = txShift[`PVMP_SLOT_BITS-1];
        next_txShift = {txShift[`PVMP_SLOT_BITS-2:0], 1'h0};
      end else begin
        next_serOut  = IdleLevel;
      end
    end
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      bitIdx    <= LastBit;
      frameSync <= 1'h0;
      serOut    <= IdleLevel;
      txShift   <= `PVMP_SAMPLE_RESET;
    end else if (en) begin
      bitIdx    <= next_bitIdx;
      frameSync <= next_frameSync;
      serOut    <= next_serOut;
      txShift   <= next_txShift;
    end
  end

  // ----------------------------------------------------------------------
  // Receive sequencer
  // ----------------------------------------------------------------------
  pvmp_pkg::pvmp_rx_e     rxState;
  pvmp_pkg::pvmp_rx_e     next_rxState;
  pvmp_pkg::pvmp_rxcnt_t  rxCount;
  pvmp_pkg::pvmp_rxcnt_t  next_rxCount;
  pvmp_pkg::pvmp_sample_t rxShift;
  pvmp_pkg::pvmp_sample_t next_rxShift;
  pvmp_pkg::pvmp_sample_t next_rxData;
  logic                   next_rxValid;

  // Primed at frame start; the first falling edge after it is bit zero
  always_comb begin
    next_rxState = rxState;
    next_rxCount = rxCount;
    next_rxShift = rxShift;
    next_rxData  = rxData;
    next_rxValid = 1'h0;
    case (rxState)
      pvmp_pkg::RX_IDLE: begin
        if (frameStart) begin
          next_rxState = pvmp_pkg::RX_SHIFT;
          next_rxCount = 4'h0;
        end
      end
      pvmp_pkg::RX_SHIFT: begin
        if (tickBus.sampleTick) begin
          next_rxShift = {rxShift[`PVMP_SLOT_BITS-2:0], serInSync};
          next_rxCount = rxCount + 4'h1;
          if (rxCount == LastRxBit) begin
            next_rxData  = {rxShift[`PVMP_SLOT_BITS-2:0], serInSync};
            next_rxValid = 1'h1;
            next_rxState = pvmp_pkg::RX_IDLE;
          end
        end
      end
      default: begin
        next_rxState = pvmp_pkg::RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      rxState <= pvmp_pkg::RX_IDLE;
      rxCount <= 4'h0;
      rxShift <= `PVMP_SAMPLE_RESET;
      rxData  <= `PVMP_SAMPLE_RESET;
      rxValid <= 1'h0;
    end else if (en) begin
      rxState <= next_rxState;
      rxCount <= next_rxCount;
      rxShift <= next_rxShift;
      rxData  <= next_rxData;
      rxValid <= next_rxValid;
    end
  end

  // ----------------------------------------------------------------------
  // Check helpers
  // ----------------------------------------------------------------------
  localparam int FrameCyc   = `PVMP_FRAME_CYC;
  localparam int HalfMinCyc = `PVMP_HALF_MIN_CYC;
  localparam int HalfMaxCyc = `PVMP_HALF_MAX_CYC;

  logic [13:0] frameCyc;
  logic [7:0]  halfCnt;
  logic        lastSync;
  logic        lastBitClk;
  logic        seenFrame;
  logic        seenEdge;
  logic        txMsb;

  assign txMsb = txData[`PVMP_SLOT_BITS-1];

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      frameCyc   <= 14'h0000;
      halfCnt    <= 8'h00;
      lastSync   <= 1'h0;
      lastBitClk <= 1'h0;
      seenFrame  <= 1'h0;
      seenEdge   <= 1'h0;
    end else if (en) begin
      lastSync   <= frameSync;
      lastBitClk <= bitClk;
      frameCyc   <= (frameSync & ~lastSync) ? 14'h0000 : (frameCyc + 14'h0001);
      halfCnt    <= (bitClk != lastBitClk) ? 8'h00 : (halfCnt + 8'h01);
      seenFrame  <= seenFrame | (frameSync & ~lastSync);
      seenEdge   <= seenEdge | (bitClk != lastBitClk);
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSyncN || !en);

  sequence s_sync_rise;
    $rose(frameSync);
  endsequence

  sequence s_clk_follow;
    ##SyncLeadCyc $rose(bitClk);
  endsequence

  a_sync_frame_period: assert property ($rose(frameSync) && seenFrame |->
                                        frameCyc == 14'(FrameCyc - 1))
    else $error("frame sync period is not one frame");
  a_sync_clk_lead: assert property (s_sync_rise |-> s_clk_follow)
    else $error("bit clock does not rise the lead count after sync");
  a_sync_long_pulse: assert property (s_sync_rise |=> frameSync [*8])
    else $error("frame sync pulse too short");
  a_sync_fall_bit: assert property ($fell(frameSync) |-> bitIdx == SyncHighBits)
    else $error("frame sync fell at the wrong bit");
  a_clk_half_period: assert property (seenEdge && (bitClk != lastBitClk) |->
                                      (halfCnt >= 8'(HalfMinCyc - 1)) &&
                                      (halfCnt <= 8'(HalfMaxCyc - 1)))
    else $error("bit clock half period out of range");
  a_tx_load_msb: assert property (txReady && txValid |=> serOut == $past(txMsb))
    else $error("first bit sent is not the sample MSB");
  a_tx_idle_slots: assert property ((bitIdx >= SlotEnd) |-> serOut == IdleLevel)
    else $error("data driven outside the active slot");
  a_frame_ready: assert property (s_sync_rise |-> $past(txReady))
    else $error("frame started without a sample request");
  a_rx_one_word: assert property (rxValid |=> !rxValid [*8])
    else $error("receive word strobe repeated");
  a_rx_lsb_last: assert property (rxValid |-> rxData[0] == $past(serInSync))
    else $error("last received bit is not the word LSB");
  a_rx_in_slot: assert property (rxValid |-> bitIdx == (SlotEnd - 7'h01))
    else $error("receive word completed outside the active slot");

endmodule : pcm_voice_master_port

// ### bench/pvmp_codec_model.sv
/*
  Behavioural model of the voice codec on the far side of the serial port.
  Assumes the port is frame master and drives frame sync and bit clock.
*/
`timescale 1ns/100ps

module pvmp_codec_model (
  // Port pins
  input  wire logic                   frameSync,
  input  wire logic                   bitClk,
  input  wire logic                   serOut,
  output logic                        serIn,
  // Test control
  input  wire logic                   floatIn,
  input  wire pvmp_pkg::pvmp_sample_t sendWord,
  output pvmp_pkg::pvmp_sample_t      gotWord,
  output int                          idleBad
);
  // ----------------------------------------------------------------------
  // Slot tracking
  // ----------------------------------------------------------------------
  int                     bitIdx = 96;
  pvmp_pkg::pvmp_sample_t word;

  initial begin
    serIn   = 1'h1;
    gotWord = 16'h0000;
    idleBad = 0;
  end

  always @(posedge frameSync) begin
    bitIdx = 0;
    word   = sendWord;
  end

  // Data changes on the rising edge so it is settled at the falling one
  always @(posedge bitClk) begin
    if (floatIn) begin
      serIn <= 1'h1; // Pull-up holds a floated line high
    end else if (bitIdx < 16) begin
      serIn <= word[15 - bitIdx];
    end else begin
      serIn <= ~serIn; // Unused slots carry no stable value
    end
  end

  always @(negedge bitClk) begin
    if (bitIdx < 16) begin
      gotWord[15 - bitIdx] = serOut;
    end else if (serOut !== 1'h1) begin
      idleBad = idleBad + 1;
    end
    if (bitIdx < 96) begin
      bitIdx = bitIdx + 1;
    end
  end
endmodule : pvmp_codec_model

// ### bench/pcm_voice_master_port_tb_top.sv
/*
  Self-checking bench for the voice serial port with a codec model.
  Assumes a 100 MHz clock and the fixed frame of 12500 cycles.
*/
`timescale 1ns/100ps

module pcm_voice_master_port_tb_top;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic                   clk = 1'h0;
  logic                   rst_n = 1'h0;
  logic                   en = 1'h1;
  pvmp_pkg::pvmp_sample_t txData = 16'h0000;
  logic                   txValid = 1'h0;
  logic                   txReady;
  pvmp_pkg::pvmp_sample_t rxData;
  logic                   rxValid;
  logic                   frameSync;
  logic                   bitClk;
  logic                   serOut;
  logic                   serIn;
  logic                   floatIn = 1'h0;
  pvmp_pkg::pvmp_sample_t sendWord = 16'h0000;
  pvmp_pkg::pvmp_sample_t gotWord;
  int                     idleBad;
  int                     errors = 0;
  int                     samples_checked = 0;

  typedef struct {
    logic [15:0] tx;
    logic        valid;
    logic [15:0] rx;
  } pvmp_row_s;
  pvmp_row_s rows [5] = '{
    '{16'h8001, 1'h1, 16'h7ffe}, '{16'ha5c3, 1'h1, 16'h3c5a},
    '{16'h0000, 1'h1, 16'hffff}, '{16'hffff, 1'h1, 16'h0001},
    '{16'h1234, 1'h0, 16'h8000}};

  always #5 clk = ~clk;

  pcm_voice_master_port pcm_voice_master_port_inst (
    .clk(clk), .rst_n(rst_n), .en(en), .txData(txData), .txValid(txValid),
    .txReady(txReady), .rxData(rxData), .rxValid(rxValid), .frameSync(frameSync),
    .bitClk(bitClk), .serOut(serOut), .serIn(serIn));

  pvmp_codec_model pvmp_codec_model_inst (
    .frameSync(frameSync), .bitClk(bitClk), .serOut(serOut), .serIn(serIn),
    .floatIn(floatIn), .sendWord(sendWord), .gotWord(gotWord), .idleBad(idleBad));

  // ----------------------------------------------------------------------
  // Frame monitor, snapshot at every frame start
  // ----------------------------------------------------------------------
  int   cyc, highCnt, rises, lead, syncAt, hc, hMin, hMax;
  int   fLen, fHigh, fRises, fLead, fMin, fMax;
  logic prevSync, prevBit;
  logic [2:0] pins;

  always @(posedge clk) begin
    if (txReady === 1'h1) begin
      fLen = cyc; fHigh = highCnt; fRises = rises; fLead = lead;
      fMin = hMin; fMax = hMax;
      cyc = 1; highCnt = 0; rises = 0; lead = -1; hMin = 999; hMax = 0;
    end else begin
      cyc = cyc + 1;
    end
    if (frameSync === 1'h1) highCnt = highCnt + 1;
    if (frameSync === 1'h1 && prevSync === 1'h0) syncAt = cyc;
    if (bitClk !== prevBit) begin
      // First half period of each frame is skipped: it may start inside reset
      if (rises > 0 && hc < hMin) hMin = hc;
      if (rises > 0 && hc > hMax) hMax = hc;
      hc = 1;
      if (bitClk === 1'h1) begin
        if (lead < 0) lead = cyc - syncAt;
        rises = rises + 1;
      end
    end else begin
      hc = hc + 1;
    end
    prevSync = frameSync;
    prevBit  = bitClk;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %0h seen %0h", name, exp, got);
    end
  endtask : check

  // Bounded wait on txReady (sel 0) or rxValid (sel 1)
  task automatic wait_sig(input int sel);
    for (int n = 0; n < 13000; n++) begin
      @(posedge clk);
      #1;
      if (sel == 0 ? txReady === 1'h1 : rxValid === 1'h1) return;
    end
    errors++;
    $display("unexpected %s: expected 1 seen 0 within 13000 cycles",
             sel == 0 ? "txReady" : "rxValid");
    test_done();
  endtask : wait_sig

  task automatic load_row(input int i);
    @(posedge clk);
    txData   <= rows[i].tx;
    txValid  <= rows[i].valid;
    sendWord <= rows[i].rx;
  endtask : load_row

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    load_row(0);
    wait_sig(0);
    for (int i = 0; i < 5; i++) begin
      wait_sig(1);
      check("rxData", rows[i].rx, rxData);
      load_row((i + 1) % 5);
      wait_sig(0);
      @(posedge clk);
      #1;
      check("serOut word", rows[i].valid ? rows[i].tx : 16'h0000, gotWord);
      check("frame length", 12500, fLen);
      check("bit clocks", 96, fRises);
      check("sync lead", 15, fLead);
      check("sync high", 1, fHigh >= 3124 && fHigh <= 3126);
      check("half period", 1, fMin >= 65 && fMax <= 66);
      check("idle bits", 0, idleBad);
    end
    // Floating input still yields a word each frame
    floatIn <= 1'h1;
    wait_sig(1);
    check("float rxData", 16'hffff, rxData);
    floatIn <= 1'h0;
    // Clock enable low freezes pins and strobes for longer than a half bit
    @(posedge clk);
    en <= 1'h0;
    @(posedge clk);
    #1;
    pins = {frameSync, bitClk, serOut};
    repeat (150) @(posedge clk);
    #1;
    check("frozen pins", pins, {frameSync, bitClk, serOut});
    check("frozen txReady", 0, txReady);
    @(posedge clk);
    en <= 1'h1;
    // Reset in mid-frame
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
    check("reset pins", 3'h1, {frameSync, bitClk, serOut});
    check("reset stream", 18'h0, {txReady, rxValid, rxData});
    @(posedge clk);
    rst_n <= 1'h1;
    load_row(1);
    wait_sig(0);
    wait_sig(1);
    check("rxData after reset", rows[1].rx, rxData);
    test_done();
  end
endmodule : pcm_voice_master_port_tb_top
